// File: src/ubc_clock_select.sv
// ubc_clock_select: bit clock selection for four blocks of two channels
// assumes an APB master on core_clk_i and asynchronous multi-purpose pins
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module ubc_clock_select
  import ubc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [UBC_CHANNELS-1:0] multi_input_one_i,
  input wire logic [UBC_CHANNELS-1:0] multi_input_two_i,
  input wire logic [UBC_CHANNELS-1:0] multi_input_three_i,
  output logic [UBC_CHANNELS-1:0] rx_bit_tick_o,
  output logic [UBC_CHANNELS-1:0] tx_bit_tick_o,
  output logic [UBC_BLOCKS-1:0] timer_wave_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // registers
  logic [7:0] csel_reg [UBC_CHANNELS];
  logic [7:0] aux_reg [UBC_BLOCKS];
  logic [7:0] upper_reg [UBC_BLOCKS];
  logic [7:0] lower_reg [UBC_BLOCKS];
  logic [31:0] prdata_reg;
  logic err_reg;

  // bus decode
  logic [31:0] rdata_next;
  logic err_next;
  logic sel_csel;
  logic sel_blk;
  logic [2:0] ch_idx;
  logic [1:0] blk_idx;
  logic [1:0] blk_ofs;
  logic wr_take;

  // pin synchronisers
  logic [UBC_CHANNELS-1:0] in1_s1_reg;
  logic [UBC_CHANNELS-1:0] in1_s2_reg;
  logic [UBC_CHANNELS-1:0] in1_s3_reg;
  logic [UBC_CHANNELS-1:0] in2_s1_reg;
  logic [UBC_CHANNELS-1:0] in2_s2_reg;
  logic [UBC_CHANNELS-1:0] in2_s3_reg;
  logic [UBC_CHANNELS-1:0] in3_s1_reg;
  logic [UBC_CHANNELS-1:0] in3_s2_reg;
  logic [UBC_CHANNELS-1:0] in3_s3_reg;
  logic [UBC_CHANNELS-1:0] in1_edge;
  logic [UBC_CHANNELS-1:0] in2_edge;
  logic [UBC_CHANNELS-1:0] in3_edge;

  // timers
  logic [2:0] tsrc [UBC_BLOCKS];
  logic [15:0] preset [UBC_BLOCKS];
  logic [15:0] tcnt_reg [UBC_BLOCKS];
  logic [3:0] pre16_reg [UBC_BLOCKS];
  logic [UBC_BLOCKS-1:0] tact;
  logic [UBC_BLOCKS-1:0] traw;
  logic [UBC_BLOCKS-1:0] tdiv;
  logic [UBC_BLOCKS-1:0] ttick;
  logic [UBC_BLOCKS-1:0] tend;
  logic [UBC_BLOCKS-1:0] wave_reg;
  logic [UBC_BLOCKS-1:0] rise_reg;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------

  always_comb
  begin
    sel_csel = 1'b0;
    sel_blk = 1'b0;
    err_next = 1'b0;
    rdata_next = '0;
    ch_idx = paddr_i[4:2];
    blk_idx = paddr_i[5:4];
    blk_ofs = paddr_i[3:2];
    if (paddr_i[1:0] != 2'b00)
    begin
      err_next = 1'b1;
    end
    else if (paddr_i[7:5] == UBC_CSEL_PAGE)
    begin
      sel_csel = 1'b1;
      rdata_next = {24'h000000, csel_reg[ch_idx]};
    end
    else if (paddr_i[7:6] == UBC_BLK_PAGE)
    begin
      sel_blk = 1'b1;
      if (blk_ofs == UBC_AUX_IDX)
      begin
        rdata_next = {24'h000000, aux_reg[blk_idx]};
      end
      else if (blk_ofs == UBC_UPPER_IDX)
      begin
        rdata_next = {24'h000000, upper_reg[blk_idx]};
      end
      else if (blk_ofs == UBC_LOWER_IDX)
      begin
        rdata_next = {24'h000000, lower_reg[blk_idx]};
      end
      else
      begin
        err_next = 1'b1;
      end
    end
    else if (paddr_i == UBC_STATUS_ADDR)
    begin
      rdata_next = {28'h0000000, wave_reg};
    end
    else
    begin
      err_next = 1'b1;
    end
  end

  // read data is caught in the setup cycle so the access phase needs no wait
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      prdata_reg <= '0;
      err_reg <= 1'b0;
    end
    else if (psel_i && !penable_i)
    begin
      prdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  assign pready_o = 1'b1;
  assign prdata_o = prdata_reg;
  assign pslverr_o = psel_i && penable_i && err_reg;
  assign wr_take = psel_i && penable_i && pwrite_i && !err_next;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < UBC_CHANNELS; c++)
      begin
        csel_reg[c] <= UBC_CSEL_RST;
      end
    end
    else if (wr_take && sel_csel)
    begin
      csel_reg[ch_idx] <= pwdata_i[7:0];
    end
  end

  // per-block aux and preset; divisor load
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      for (int b = 0; b < UBC_BLOCKS; b++)
      begin
        aux_reg[b] <= UBC_AUX_RST;
        upper_reg[b] <= UBC_UPPER_RST;
        lower_reg[b] <= UBC_LOWER_RST;
      end
    end
    else if (wr_take && sel_blk)
    begin
      if (blk_ofs == UBC_AUX_IDX)
      begin
        aux_reg[blk_idx] <= pwdata_i[7:0];
      end
      else if (blk_ofs == UBC_UPPER_IDX)
      begin
        upper_reg[blk_idx] <= pwdata_i[7:0];
      end
      else
      begin
        lower_reg[blk_idx] <= pwdata_i[7:0];
      end
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------

  // two flops, then a third for edge detect
  // no reset: a pin held high through reset must not give a false edge
  always_ff @(posedge core_clk_i)
  begin
    in1_s1_reg <= multi_input_one_i;
    in1_s2_reg <= in1_s1_reg;
    in1_s3_reg <= in1_s2_reg;
    in2_s1_reg <= multi_input_two_i;
    in2_s2_reg <= in2_s1_reg;
    in2_s3_reg <= in2_s2_reg;
    in3_s1_reg <= multi_input_three_i;
    in3_s2_reg <= in3_s1_reg;
    in3_s3_reg <= in3_s2_reg;
  end

  // rising edges become one-cycle enables
  assign in1_edge = in1_s2_reg & ~in1_s3_reg;
  assign in2_edge = in2_s2_reg & ~in2_s3_reg;
  assign in3_edge = in3_s2_reg & ~in3_s3_reg;

  // ----------------------------------------
  // block timers
  // ----------------------------------------

  // timer clock source; counter modes leave the timer idle
  always_comb
  begin
    for (int b = 0; b < UBC_BLOCKS; b++)
    begin
      tsrc[b] = aux_reg[b][UBC_TSRC_HI:UBC_TSRC_LO];
      preset[b] = {upper_reg[b], lower_reg[b]};
      tact[b] = (tsrc[b] == UBC_TSRC_PIN) || (tsrc[b] == UBC_TSRC_PIN16)
        || (tsrc[b] == UBC_TSRC_OSC) || (tsrc[b] == UBC_TSRC_OSC16);
      // pin one of the block's first channel
      traw[b] = ((tsrc[b] == UBC_TSRC_OSC) || (tsrc[b] == UBC_TSRC_OSC16))
        ? 1'b1 : in1_edge[2 * b];
      tdiv[b] = (tsrc[b] == UBC_TSRC_PIN16) || (tsrc[b] == UBC_TSRC_OSC16);
      ttick[b] = tact[b] && traw[b] && (!tdiv[b] || pre16_reg[b] == UBC_DIV16_END);
      tend[b] = (tcnt_reg[b] <= UBC_TIMER_END);
    end
  end

  // half period of preset ticks; a new preset lands at the next reload
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      for (int b = 0; b < UBC_BLOCKS; b++)
      begin
        tcnt_reg[b] <= {UBC_UPPER_RST, UBC_LOWER_RST};
        pre16_reg[b] <= '0;
      end
      wave_reg <= '0;
      rise_reg <= '0;
    end
    else
    begin
      for (int b = 0; b < UBC_BLOCKS; b++)
      begin
        rise_reg[b] <= ttick[b] && tend[b] && !wave_reg[b];
        if (!tact[b])
        begin
          tcnt_reg[b] <= preset[b];
          pre16_reg[b] <= '0;
          wave_reg[b] <= 1'b0;
        end
        else
        begin
          if (traw[b])
          begin
            pre16_reg[b] <= pre16_reg[b] + 4'h1;
          end
          if (ttick[b] && tend[b])
          begin
            tcnt_reg[b] <= preset[b];
            wave_reg[b] <= ~wave_reg[b];
          end
          else if (ttick[b])
          begin
            tcnt_reg[b] <= tcnt_reg[b] - 16'h0001;
          end
        end
      end
    end
  end

  assign timer_wave_o = wave_reg;

  // per-block checks
  for (genvar b = 0; b < UBC_BLOCKS; b++)
  begin : g_blk
    logic [15:0] h_ticks_reg;
    logic [7:0] h_aux_reg;
    logic [15:0] h_pre_reg;
    logic h_clean_reg;
    logic h_chg;

    assign h_chg = (h_aux_reg != aux_reg[b]) || (h_pre_reg != preset[b]);

    // timer ticks since the last toggle under steady settings
    always_ff @(posedge core_clk_i)
    begin
      h_aux_reg <= aux_reg[b];
      h_pre_reg <= preset[b];
      if (rst_i || h_chg || !tact[b])
      begin
        h_ticks_reg <= '0;
        h_clean_reg <= 1'b0;
      end
      else if (ttick[b] && tend[b])
      begin
        h_ticks_reg <= '0;
        h_clean_reg <= 1'b1;
      end
      else
      begin
        h_ticks_reg <= h_ticks_reg + {15'h0000, ttick[b]};
      end
    end

    // half period; divisor not below minimum
    property p_half_period;
      ttick[b] && tend[b] && h_clean_reg && !h_chg && preset[b] >= UBC_PRESET_MIN
        |-> h_ticks_reg + 16'h0001 == preset[b];
    endproperty
    a_half_period: assert property (p_half_period)
      else $error("timer half period differs from preset");

    property p_osc_source;
      tsrc[b] == UBC_TSRC_OSC |-> ttick[b];
    endproperty
    a_osc_source: assert property (p_osc_source)
      else $error("oscillator timer clock missed a cycle");

    property p_pin_source;
      tsrc[b] == UBC_TSRC_PIN |-> ttick[b] == in1_edge[2 * b];
    endproperty
    a_pin_source: assert property (p_pin_source)
      else $error("timer pin clock not from the block's first channel");
  end

  // ----------------------------------------
  // channel bit clocks
  // ----------------------------------------

  // two channels per block share one timer
  for (genvar c = 0; c < UBC_CHANNELS; c++)
  begin : g_chan
    // receiver from select bits 7:4 and pin three
    ubc_bit_gen u_rx
    (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .sel_i(csel_reg[c][UBC_RX_SEL_HI:UBC_RX_SEL_LO]),
      .rate_set_i(aux_reg[c / 2][UBC_RATE_SET_BIT]),
      .timer_tick_i(rise_reg[c / 2]),
      .ext_tick_i(in3_edge[c]),
      .bit_tick_o(rx_bit_tick_o[c])
    );

    // transmitter from select bits 3:0 and pin two
    ubc_bit_gen u_tx
    (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .sel_i(csel_reg[c][UBC_TX_SEL_HI:UBC_TX_SEL_LO]),
      .rate_set_i(aux_reg[c / 2][UBC_RATE_SET_BIT]),
      .timer_tick_i(rise_reg[c / 2]),
      .ext_tick_i(in2_edge[c]),
      .bit_tick_o(tx_bit_tick_o[c])
    );

    property p_rx_pin;
      csel_reg[c][UBC_RX_SEL_HI:UBC_RX_SEL_LO] == UBC_SEL_EXT1 && in3_edge[c]
        |=> rx_bit_tick_o[c];
    endproperty
    a_rx_pin: assert property (p_rx_pin)
      else $error("receiver ignored its 1x pin");

    property p_tx_pin;
      csel_reg[c][UBC_TX_SEL_HI:UBC_TX_SEL_LO] == UBC_SEL_EXT1 && in2_edge[c]
        |=> tx_bit_tick_o[c];
    endproperty
    a_tx_pin: assert property (p_tx_pin)
      else $error("transmitter ignored its 1x pin");

    // pin edge after two sync flops
    property p_sync_edge;
      $rose(multi_input_three_i[c]) |-> ##2 in3_edge[c];
    endproperty
    a_sync_edge: assert property (p_sync_edge)
      else $error("pin edge not seen two cycles later");
  end

  // a select write to channel 0 lands there and leaves channel 1 alone
  property p_csel_write;
    wr_take && sel_csel && ch_idx == 3'h0 |=> csel_reg[0] == $past(pwdata_i[7:0])
      && $stable(csel_reg[1]);
  endproperty
  a_csel_write: assert property (p_csel_write)
    else $error("clock select write misplaced");
endmodule

// File: include/ubc_pkg.sv
// ubc_pkg: constants for the baud clock selection block
// assumes core_clk_i stands in for the oscillator clock; APB register access
// Functional notes
// - Four identical blocks, each with two channels and one shared timer.
// - A register acts either on a whole block or on one channel.
// - Select bits 7:4 pick the receiver clock, 3:0 the transmitter, aux bit 7 the rate set.
// - Rate set 0 codes 0000 to 1100 give 50 up to 38.4K baud at nominal clock.
// - Rate set 1 codes 0000 to 1100 give 75 up to 38.4K baud at nominal clock.
// - Each fixed rate is the oscillator clock over a fixed ratio per code and set.
// - Receiver code 1110 takes pin three as 16X clock, 1111 as 1X clock.
// - Transmitter code 1110 takes pin two as 16X clock, 1111 as 1X clock.
// - In 16X mode one bit lasts sixteen external clocks, kept at or under 2MHz.
// - In 1X mode one bit lasts one external clock, kept at or under 1MHz.
// - Code 1101 uses the block timer output as the 16X clock.
// - Aux bits 6:4 pick the timer clock: pin, pin/16, oscillator, oscillator/16.
// - Only pin one of channels a, c, e and g clocks its block timer.
// - The timer square wave period is twice the divisor in timer clocks.
package ubc_pkg;
  localparam int UBC_BLOCKS = 4;
  localparam int UBC_CHANNELS = 8;

  // register map, byte addresses
  localparam logic [2:0] UBC_CSEL_PAGE = 3'h0;    // 0x00 + 4 * channel
  localparam logic [1:0] UBC_BLK_PAGE = 2'h1;     // 0x40 + 0x10 * block
  localparam logic [1:0] UBC_AUX_IDX = 2'h0;
  localparam logic [1:0] UBC_UPPER_IDX = 2'h1;
  localparam logic [1:0] UBC_LOWER_IDX = 2'h2;
  localparam logic [7:0] UBC_STATUS_ADDR = 8'h80;

  // field positions
  localparam int UBC_RX_SEL_HI = 7;
  localparam int UBC_RX_SEL_LO = 4;
  localparam int UBC_TX_SEL_HI = 3;
  localparam int UBC_TX_SEL_LO = 0;
  localparam int UBC_RATE_SET_BIT = 7;
  localparam int UBC_TSRC_HI = 6;
  localparam int UBC_TSRC_LO = 4;

  // reset values
  localparam logic [7:0] UBC_CSEL_RST = 8'h00;
  localparam logic [7:0] UBC_AUX_RST = 8'h00;
  localparam logic [7:0] UBC_UPPER_RST = 8'h00;
  localparam logic [7:0] UBC_LOWER_RST = 8'h02;

  // timer clock sources
  localparam logic [2:0] UBC_TSRC_PIN = 3'h4;
  localparam logic [2:0] UBC_TSRC_PIN16 = 3'h5;
  localparam logic [2:0] UBC_TSRC_OSC = 3'h6;
  localparam logic [2:0] UBC_TSRC_OSC16 = 3'h7;

  // bit clock select codes and counts
  localparam logic [3:0] UBC_SEL_LAST_FIXED = 4'hC;
  localparam logic [3:0] UBC_SEL_TIMER = 4'hD;
  localparam logic [3:0] UBC_SEL_EXT16 = 4'hE;
  localparam logic [3:0] UBC_SEL_EXT1 = 4'hF;
  localparam logic [16:0] UBC_X16_LIMIT = 17'h0000F;
  localparam logic [3:0] UBC_DIV16_END = 4'hF;
  localparam logic [15:0] UBC_TIMER_END = 16'h0001;
  localparam logic [15:0] UBC_PRESET_MIN = 16'h0002;

  localparam logic [16:0] UBC_RATIO_SET0 [13] = '{17'h12000, 17'h08300, 17'h06B00,
    17'h04800, 17'h03000, 17'h01800, 17'h00C00, 17'h00DC0, 17'h00600, 17'h00300,
    17'h00200, 17'h00180, 17'h00060};
  localparam logic [16:0] UBC_RATIO_SET1 [13] = '{17'h0C000, 17'h08300, 17'h00060,
    17'h06000, 17'h03000, 17'h01800, 17'h00C00, 17'h00730, 17'h00600, 17'h00300,
    17'h00800, 17'h00180, 17'h000C0};

  function automatic logic [16:0] ubc_ratio(input logic set_i, input logic [3:0] code_i);
    logic [16:0] r;
    r = '0;
    if (code_i <= UBC_SEL_LAST_FIXED)
    begin
      r = set_i ? UBC_RATIO_SET1[code_i] : UBC_RATIO_SET0[code_i];
    end
    return r;
  endfunction
endpackage

// File: src/ubc_bit_gen.sv
// ubc_bit_gen: one receiver or transmitter bit clock enable
// assumes timer and pin ticks are one-cycle pulses on core_clk_i
`timescale 1ns/100ps
module ubc_bit_gen
  import ubc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] sel_i,
  input wire logic rate_set_i,
  input wire logic timer_tick_i,
  input wire logic ext_tick_i,
  output logic bit_tick_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  logic fixed;
  logic step;
  logic [16:0] limit;
  logic [16:0] cnt_reg;
  logic tick_reg;

  // source and terminal count for the selected code
  always_comb
  begin
    fixed = (sel_i <= UBC_SEL_LAST_FIXED);
    step = 1'b1;
    limit = UBC_X16_LIMIT;
    if (fixed)
    begin
      limit = ubc_ratio(rate_set_i, sel_i) - 17'h00001;
    end
    else if (sel_i == UBC_SEL_TIMER)
    begin
      step = timer_tick_i;
    end
    else if (sel_i == UBC_SEL_EXT16)
    begin
      step = ext_tick_i;
    end
    else
    begin
      step = ext_tick_i;
      limit = '0;
    end
  end

  // divider; a code change mid-count only stretches or shortens one bit
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= step && (cnt_reg >= limit);
      if (step)
      begin
        cnt_reg <= (cnt_reg >= limit) ? '0 : cnt_reg + 17'h00001;
      end
    end
  end

  assign bit_tick_o = tick_reg;

  // checking helpers: steps between ticks under a steady code
  logic [4:0] h_mode_reg;
  logic [16:0] h_steps_reg;
  logic h_clean_reg;
  logic h_chg;

  assign h_chg = (h_mode_reg != {rate_set_i, sel_i});

  always_ff @(posedge core_clk_i)
  begin
    h_mode_reg <= {rate_set_i, sel_i};
    if (rst_i || h_chg)
    begin
      h_steps_reg <= '0;
      h_clean_reg <= 1'b0;
    end
    else if (tick_reg)
    begin
      h_steps_reg <= {16'h0000, step};
      h_clean_reg <= 1'b1;
    end
    else
    begin
      h_steps_reg <= h_steps_reg + {16'h0000, step};
    end
  end

  property p_fixed_period;
    bit_tick_o && h_clean_reg && !h_chg && fixed |-> h_steps_reg == limit + 17'h00001;
  endproperty
  a_fixed_period: assert property (p_fixed_period)
    else $error("fixed rate bit period wrong");

  property p_x16_period;
    bit_tick_o && h_clean_reg && !h_chg && !fixed && sel_i != UBC_SEL_EXT1
      |-> h_steps_reg == UBC_X16_LIMIT + 17'h00001;
  endproperty
  a_x16_period: assert property (p_x16_period)
    else $error("16x mode did not take sixteen clocks per bit");

  property p_x1_follow;
    sel_i == UBC_SEL_EXT1 && ext_tick_i |=> bit_tick_o;
  endproperty
  a_x1_follow: assert property (p_x1_follow)
    else $error("1x clock edge gave no bit tick");
endmodule

// File: verif/ubc_pin_src.sv
// ubc_pin_src: external clock source for the multi-purpose pins
// assumes core_clk_i paces it; all pins idle low while disabled
`timescale 1ns/100ps
module ubc_pin_src
(
  input wire logic core_clk_i,
  input wire logic en_i,
  input wire logic [7:0] half_i,
  output logic [7:0] pin_o
);
  logic [7:0] cnt_reg;

  // ----------------------------------------
  // pin clock generator
  // ----------------------------------------
  // rate kept under limit
  // half period of 50 cycles keeps the pins at 1MHz, legal for 1X and 16X
  always_ff @(posedge core_clk_i)
  begin
    if (!en_i)
    begin
      cnt_reg <= 8'h00;
      pin_o <= 8'h00;
    end
    else if (cnt_reg == half_i - 8'h01)
    begin
      cnt_reg <= 8'h00;
      pin_o <= ~pin_o;
    end
    else
    begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule

// File: verif/test_uart_baud_clock_select.sv
// test_uart_baud_clock_select: self-checking bench for baud clock selection
// assumes zero-wait APB slave and tick spacing measured in core clock cycles
`timescale 1ns/100ps
module test_uart_baud_clock_select;
  import ubc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic en_i = 1'b0;
  logic [7:0] pin;
  logic [7:0] pin_two;
  logic [7:0] pin_one;
  logic [7:0] rx_bit_tick_o;
  logic [7:0] tx_bit_tick_o;
  logic [3:0] timer_wave_o;
  int n_mismatch = 0;
  int checks = 0;
  logic [7:0] fx_aux [4] = '{8'h00, 8'h80, 8'h80, 8'h00};
  logic [7:0] fx_csel [4] = '{8'hCB, 8'h2C, 8'h7A, 8'hA7};
  int fx_rx [4] = '{96, 96, 1840, 512};
  int fx_tx [4] = '{384, 192, 2048, 3520};
  int fx_ch [4] = '{0, 7, 3, 4};

  ubc_clock_select ubc_clock_select_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .multi_input_one_i(pin_one & 8'h55), .multi_input_two_i(pin_two),
    .multi_input_three_i(pin),
    .rx_bit_tick_o(rx_bit_tick_o), .tx_bit_tick_o(tx_bit_tick_o),
    .timer_wave_o(timer_wave_o));

  // three pin rates, so a pin routed to the wrong clock shows as a wrong gap
  ubc_pin_src ubc_pin_src_i (.core_clk_i(core_clk_i), .en_i(en_i), .half_i(8'h32),
    .pin_o(pin));
  ubc_pin_src ubc_pin_src_two_i (.core_clk_i(core_clk_i), .en_i(en_i), .half_i(8'h3C),
    .pin_o(pin_two));
  ubc_pin_src ubc_pin_src_one_i (.core_clk_i(core_clk_i), .en_i(en_i), .half_i(8'h28),
    .pin_o(pin_one));

  // 100 MHz core clock
  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("counts: %0d checks, %0d mismatches", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // second reset in mid-run also restarts every bit divider from zero and every timer count from 2
  task automatic rst_pulse;
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
  endtask

  // one APB transfer; a read compares against d, every transfer checks the error flag
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic e_exp);
    logic [31:0] q;
    logic e;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    // no limit of its own: only the watchdog ends a stuck wait
    do
    begin
      @(posedge core_clk_i);
    end
    while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    cmp({31'h0, e}, {31'h0, e_exp});
    if (!w)
      cmp(q, d);
  endtask

  function automatic logic [7:0] blk(input int b, input int off);
    return 8'(64 + 16 * b + off);
  endfunction

  function automatic logic pick(input int sel, input int ch);
    case (sel)
      0: return rx_bit_tick_o[ch];
      1: return tx_bit_tick_o[ch];
      default: return timer_wave_o[ch];
    endcase
  endfunction

  // cycles between second and third rising edge; the first gap may be odd
  task automatic gap(input int sel, input int ch, input int exp);
    int n;
    int k;
    logic p;
    logic c;
    n = 0;
    k = 0;
    p = 1'b1;
    while (k < 3 && n < 25000)
    begin
      @(posedge core_clk_i);
      #1;
      c = pick(sel, ch);
      n++;
      if (c === 1'b1 && p === 1'b0)
      begin
        k++;
        if (k < 3)
          n = 0;
      end
      p = c;
    end
    cmp(32'(n), 32'(exp));
  endtask

  // watchdog well above the expected 57k cycles
  initial
  begin
    repeat (95000) @(posedge core_clk_i);
    n_mismatch++;
    close_out;
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    rst_pulse;
    acc(1'b0, 8'h00, 32'h0, 1'b0);
    acc(1'b0, blk(0, 0), 32'h0, 1'b0);
    acc(1'b0, blk(0, 4), 32'h0, 1'b0);
    acc(1'b0, blk(0, 8), 32'h2, 1'b0);
    acc(1'b0, blk(0, 12), 32'h0, 1'b1);
    acc(1'b0, 8'h01, 32'h0, 1'b1);
    acc(1'b0, 8'h90, 32'h0, 1'b1);
    acc(1'b1, blk(0, 12), 32'hFF, 1'b1);
    acc(1'b1, 8'h1C, 32'hA5, 1'b0);
    acc(1'b0, 8'h1C, 32'hA5, 1'b0);
    acc(1'b0, 8'h18, 32'h0, 1'b0);
    acc(1'b1, 8'h80, 32'hF, 1'b0);
    acc(1'b0, 8'h80, 32'h0, 1'b0);
    acc(1'b1, blk(3, 0), 32'hC3, 1'b0);
    acc(1'b0, blk(3, 0), 32'hC3, 1'b0);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      rst_pulse;
      acc(1'b1, blk(fx_ch[i] / 2, 0), {24'h0, fx_aux[i]}, 1'b0);
      acc(1'b1, 8'(4 * fx_ch[i]), {24'h0, fx_csel[i]}, 1'b0);
      gap(0, fx_ch[i], fx_rx[i]);
      gap(1, fx_ch[i], fx_tx[i]);
    end
    $display("test fixed rates done");
    rst_pulse;
    en_i <= 1'b1;
    acc(1'b1, 8'h08, 32'hFE, 1'b0);
    acc(1'b1, 8'h14, 32'hEF, 1'b0);
    gap(0, 2, 100);
    gap(1, 2, 1920);
    gap(0, 5, 1600);
    gap(1, 5, 120);
    $display("test external clocks done");
    rst_pulse;
    acc(1'b1, blk(1, 8), 32'h3, 1'b0);
    acc(1'b1, blk(1, 0), 32'h60, 1'b0);
    acc(1'b1, 8'h0C, 32'hDD, 1'b0);
    gap(2, 1, 6);
    gap(0, 3, 96);
    gap(1, 3, 96);
    acc(1'b1, blk(1, 0), 32'h70, 1'b0);
    gap(2, 1, 96);
    acc(1'b1, blk(1, 0), 32'h40, 1'b0);
    gap(2, 1, 480);
    acc(1'b1, blk(1, 0), 32'h50, 1'b0);
    gap(2, 1, 7680);
    $display("test timer done");
    close_out;
  end
endmodule
